// ==== wit_map.svh ====
`ifndef WIT_MAP_SVH
`define WIT_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define WIT_IDX_CTRL 8'hA8
`define WIT_IDX_COUNT 8'hA9
`define WIT_IDX_RSTCTRL 8'hAB
`define WIT_IDX_EVT_STAT 8'hAC
`define WIT_IDX_EVT_EN 8'hAD
`define WIT_IDX_EVT_CLR 8'hAE

// Field positions in the control/status register
`define WIT_BIT_OVERFLOW 7
`define WIT_BIT_MODE 6
`define WIT_BIT_ENABLE 5
`define WIT_CKS_HI 2
`define WIT_CKS_LO 0

// Field positions in the reset control/status register
`define WIT_BIT_WDRESET 7
`define WIT_BIT_RSTOUT 6

// Event status bits
`define WIT_EVT_INTERVAL 0
`define WIT_EVT_WDRESET 1
`define WIT_EVT_W 2

// Reset values, counter maximum and bits that read back as one
`define WIT_CTRL_FIXED 8'h18
`define WIT_RSTCTRL_FIXED 8'h3F
`define WIT_COUNT_RESET 8'h00
`define WIT_COUNT_MAX 8'hFF

// Length of the internal reset pulse in clock cycles
`define WIT_RST_PULSE_CYC 4'h8

`endif

// ==== wit_pkg.sv ====
package wit_pkg;

    // Prescaler tap selection, divisor of the system clock
    typedef enum logic [2:0] {
        WIT_CKS_DIV2 = 3'b000,
        WIT_CKS_DIV32 = 3'b001,
        WIT_CKS_DIV64 = 3'b010,
        WIT_CKS_DIV128 = 3'b011,
        WIT_CKS_DIV256 = 3'b100,
        WIT_CKS_DIV512 = 3'b101,
        WIT_CKS_DIV2048 = 3'b110,
        WIT_CKS_DIV4096 = 3'b111
    } wit_cks_t;

    // Internal reset pulse generator
    typedef enum logic [1:0] {
        WIT_RS_IDLE = 2'b00,
        WIT_RS_PULSE = 2'b01
    } wit_rst_state_t;

endpackage : wit_pkg

// ==== wit_sync.sv ====
`timescale 1ns/1ps

// Two-stage synchroniser for levels coming from pins
module wit_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // First stage is read only by the second stage
    logic [W-1:0] meta_r;

    // Both stages take the idle level under reset
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            meta_r <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : wit_sync

// ==== wit_prescaler.sv ====
`timescale 1ns/1ps

// Clock divider: one-cycle tick at the selected division of the clock
module wit_prescaler #(
    parameter int W = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Divider control
    input wire logic run,
    input wire logic [2:0] sel,
    // Count enable pulse
    output logic tick
);

    // Free counter, held at zero while the timer is stopped
    logic [W-1:0] div_r;
    logic [W-1:0] div_nxt;
    wire [W-1:0] mask;
    wire hit;

    // Low-bit mask whose all-ones pattern marks one divided period
    function automatic logic [W-1:0] div_mask(input logic [2:0] s);
        logic [W-1:0] m;
        m = '0;
        case (wit_pkg::wit_cks_t'(s))
            wit_pkg::WIT_CKS_DIV2: m = W'(12'h001);
            wit_pkg::WIT_CKS_DIV32: m = W'(12'h01F);
            wit_pkg::WIT_CKS_DIV64: m = W'(12'h03F);
            wit_pkg::WIT_CKS_DIV128: m = W'(12'h07F);
            wit_pkg::WIT_CKS_DIV256: m = W'(12'h0FF);
            wit_pkg::WIT_CKS_DIV512: m = W'(12'h1FF);
            wit_pkg::WIT_CKS_DIV2048: m = W'(12'h7FF);
            wit_pkg::WIT_CKS_DIV4096: m = W'(12'hFFF);
            default: m = W'(12'h001);
        endcase
        return m;
    endfunction : div_mask

    assign mask = div_mask(sel);
    assign hit = ((div_r & mask) == mask);
    // Restarting from zero gives a full first period after enable
    assign div_nxt = run ? div_r + W'(1) : '0;
    assign tick = run & hit;

    // Divider register
    always_ff @(posedge clock)
    begin
        if (!nrst)
            div_r <= '0;
        else
            div_r <= div_nxt;
    end

endmodule : wit_prescaler

// ==== wit_top.sv ====
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "wit_map.svh"

// Function
// - Overflow flag clears by read-one, then write-zero
// - Watchdog overflow resets and sets reset flag
// - Reset pin or written zero clears reset flag
// - Reset flag bit 7 ignores written one
module wit_top (
    // Clock and synchronous reset
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External reset pin, active low, asynchronous
    input wire logic external_reset_pin_n,
    // Interrupt and reset outputs
    output logic irq,
    output logic wdt_reset,
    output logic reset_pin_out,
    output logic reset_pin_oe
);

    // Synchronised external reset pin
    logic pin_n_s;
    // Whole-block clear: bus reset or external pin
    wire clr;

    // Control/status fields
    logic overflow_flag_r;
    logic mode_select_bit_r;
    logic timer_enable_bit_r;
    logic [2:0] clock_select_r;
    // Set by a read that saw the overflow flag at one
    logic ovf_armed_r;
    // Counter
    logic [7:0] count_register_r;
    logic [7:0] count_nxt;
    // Reset control/status fields
    logic watchdog_reset_flag_r;
    logic reset_output_enable_r;
    // Event status and enable
    logic [`WIT_EVT_W-1:0] evt_stat_r;
    logic [`WIT_EVT_W-1:0] evt_en_r;
    logic [`WIT_EVT_W-1:0] evt_stat_nxt;
    // Reset pulse generator
    wit_pkg::wit_rst_state_t rst_state_r;
    logic [3:0] pulse_cnt_r;
    // Read data register
    logic [31:0] prdata_r;
    // Prescaler tick
    logic tick;

    // Pin passes two flip-flops before any use; idles high
    wit_sync #(
        .W(1),
        .INIT(1'b1)
    ) u_pin_sync (
        .clock(clock),
        .nrst(nrst),
        .din(external_reset_pin_n),
        .dout(pin_n_s)
    );

    assign clr = !nrst || !pin_n_s;

    // Divider for the count clock, stopped while disabled
    wit_prescaler #(
        .W(12)
    ) u_presc (
        .clock(clock),
        .nrst(!clr),
        .run(timer_enable_bit_r),
        .sel(clock_select_r),
        .tick(tick)
    );

    // Address decode: each register is one aligned word
    function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
        return (a == {2'b00, idx, 2'b00});
    endfunction : reg_hit

    wire hit_ctrl = reg_hit(paddr, `WIT_IDX_CTRL);
    wire hit_count = reg_hit(paddr, `WIT_IDX_COUNT);
    wire hit_rst = reg_hit(paddr, `WIT_IDX_RSTCTRL);
    wire hit_stat = reg_hit(paddr, `WIT_IDX_EVT_STAT);
    wire hit_en = reg_hit(paddr, `WIT_IDX_EVT_EN);
    wire hit_clr = reg_hit(paddr, `WIT_IDX_EVT_CLR);
    wire mapped = hit_ctrl | hit_count | hit_rst | hit_stat | hit_en | hit_clr;

    // Bus phases; the slave never inserts wait states
    wire setup_rd = psel && !penable && !pwrite;
    wire access = psel && penable;
    wire wr_ok = access && pwrite && mapped;
    wire rd_ok = access && !pwrite && mapped;
    wire wr_ctrl = wr_ok && hit_ctrl;
    wire wr_count = wr_ok && hit_count;
    wire wr_rst = wr_ok && hit_rst;
    wire wr_en = wr_ok && hit_en;
    wire wr_clr = wr_ok && hit_clr;
    wire rd_ctrl = rd_ok && hit_ctrl;

    // Bit 7 of the written byte
    wire wbit7 = pwdata[7];

    // Overflow when the counter rolls from its maximum; a write wins
    wire overflow = timer_enable_bit_r && tick && !wr_count &&
        (count_register_r == `WIT_COUNT_MAX);
    wire wdt_ovf = overflow && mode_select_bit_r;
    wire itv_ovf = overflow && !mode_select_bit_r;

    // Read multiplexer; unused bits read as zero, fixed ones as one
    wire [7:0] ctrl_rd = `WIT_CTRL_FIXED | {overflow_flag_r, mode_select_bit_r,
        timer_enable_bit_r, 2'b00, clock_select_r};
    wire [7:0] rst_rd = `WIT_RSTCTRL_FIXED | {watchdog_reset_flag_r,
        reset_output_enable_r, 6'h00};
    wire [7:0] rd_mux = hit_ctrl ? ctrl_rd :
        hit_count ? count_register_r :
        hit_rst ? rst_rd :
        hit_stat ? {6'h00, evt_stat_r} :
        hit_en ? {6'h00, evt_en_r} : 8'h00;

    // Bus answers
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_r;

    // Read data captured in the setup cycle, stable through the access
    always_ff @(posedge clock)
    begin
        if (clr)
            prdata_r <= 32'h00000000;
        else if (setup_rd)
            prdata_r <= {24'h000000, rd_mux};
    end

    // Overflow flag: hardware set beats the software clear
    always_ff @(posedge clock)
    begin
        if (clr)
            overflow_flag_r <= 1'b0;
        else if (overflow)
            overflow_flag_r <= 1'b1;
        else if (wr_ctrl && ovf_armed_r && !wbit7)
            overflow_flag_r <= 1'b0;
    end

    // Clear is only honoured after software has seen the flag at one
    always_ff @(posedge clock)
    begin
        if (clr)
            ovf_armed_r <= 1'b0;
        else if (rd_ctrl && overflow_flag_r)
            ovf_armed_r <= 1'b1;
        else if (wr_ctrl || !overflow_flag_r)
            ovf_armed_r <= 1'b0;
    end

    // Mode, enable and clock select; a watchdog reset returns them to idle
    always_ff @(posedge clock)
    begin
        if (clr || wdt_ovf)
        begin
            mode_select_bit_r <= 1'b0;
            timer_enable_bit_r <= 1'b0;
            clock_select_r <= 3'h0;
        end
        else if (wr_ctrl)
        begin
            mode_select_bit_r <= pwdata[`WIT_BIT_MODE];
            timer_enable_bit_r <= pwdata[`WIT_BIT_ENABLE];
            clock_select_r <= pwdata[`WIT_CKS_HI:`WIT_CKS_LO];
        end
    end

    // Counter: zero while disabled, software write beats the tick
    assign count_nxt = !timer_enable_bit_r ? `WIT_COUNT_RESET :
        wr_count ? pwdata[7:0] :
        tick ? count_register_r + 8'h01 : count_register_r;

    always_ff @(posedge clock)
    begin
        if (clr || wdt_ovf)
            count_register_r <= `WIT_COUNT_RESET;
        else
            count_register_r <= count_nxt;
    end

    // Reset flag: set by watchdog overflow, cleared by pin or written zero
    always_ff @(posedge clock)
    begin
        if (clr)
            watchdog_reset_flag_r <= 1'b0;
        else if (wdt_ovf)
            watchdog_reset_flag_r <= 1'b1;
        else if (wr_rst && !wbit7)
            watchdog_reset_flag_r <= 1'b0;
    end

    // Reset output enable survives the watchdog's own reset
    always_ff @(posedge clock)
    begin
        if (clr)
            reset_output_enable_r <= 1'b0;
        else if (wr_rst)
            reset_output_enable_r <= pwdata[`WIT_BIT_RSTOUT];
    end

    // Sticky events: set has priority over a same-cycle clear
    assign evt_stat_nxt = (evt_stat_r & ~(wr_clr ? pwdata[`WIT_EVT_W-1:0] : 2'b00)) |
        {wdt_ovf, itv_ovf};

    always_ff @(posedge clock)
    begin
        if (clr)
        begin
            evt_stat_r <= '0;
            evt_en_r <= '0;
        end
        else
        begin
            evt_stat_r <= evt_stat_nxt;
            if (wr_en)
                evt_en_r <= pwdata[`WIT_EVT_W-1:0];
        end
    end

    // Level interrupt while any enabled event is pending
    assign irq = |(evt_stat_r & evt_en_r);

    // Internal reset pulse of fixed length after a watchdog overflow
    always_ff @(posedge clock)
    begin
        if (clr)
        begin
            rst_state_r <= wit_pkg::WIT_RS_IDLE;
            pulse_cnt_r <= 4'h0;
        end
        else
        begin
            case (rst_state_r)
                wit_pkg::WIT_RS_IDLE:
                begin
                    if (wdt_ovf)
                    begin
                        rst_state_r <= wit_pkg::WIT_RS_PULSE;
                        pulse_cnt_r <= `WIT_RST_PULSE_CYC - 4'h1;
                    end
                end
                wit_pkg::WIT_RS_PULSE:
                begin
                    // Count down, the last cycle returns to idle
                    if (pulse_cnt_r == 4'h0)
                        rst_state_r <= wit_pkg::WIT_RS_IDLE;
                    else
                        pulse_cnt_r <= pulse_cnt_r - 4'h1;
                end
                default:
                    rst_state_r <= wit_pkg::WIT_RS_IDLE;
            endcase
        end
    end

    // Reset outputs; the pin is open drain, pulled low only when enabled
    assign wdt_reset = (rst_state_r == wit_pkg::WIT_RS_PULSE);
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = wdt_reset && reset_output_enable_r;

    // Watchdog reset pulse: exactly the fixed length, then released
    sequence s_rst_pulse;
        wdt_reset [*8] ##1 !wdt_reset;
    endsequence

    // Flag may only fall through the read-then-write-zero path
    AST_OVF_CLEAR_PATH: assert property (@(posedge clock) disable iff (clr)
        $fell(overflow_flag_r) |-> $past(ovf_armed_r) && $past(wr_ctrl) && !$past(wbit7))
        else $error("overflow flag fell without read and zero write");

    // Writing one never clears the overflow flag
    AST_OVF_WRITE_ONE: assert property (@(posedge clock) disable iff (clr)
        overflow_flag_r && wr_ctrl && wbit7 |=> overflow_flag_r)
        else $error("written one changed the overflow flag");

    // Watchdog overflow sets the flag and issues the reset pulse
    AST_WDT_RESET: assert property (@(posedge clock) disable iff (clr)
        wdt_ovf |=> watchdog_reset_flag_r && overflow_flag_r ##0 s_rst_pulse)
        else $error("watchdog overflow did not produce reset pulse");

    // Pin reset clears the reset flag
    AST_PIN_CLEARS: assert property (@(posedge clock) disable iff (!nrst)
        !pin_n_s |=> !watchdog_reset_flag_r && !wdt_reset)
        else $error("reset pin did not clear watchdog reset flag");

    // Written zero clears the reset flag when no overflow competes
    AST_WATCHDOG_RESET_FLAG_ZERO: assert property (@(posedge clock) disable iff (clr)
        watchdog_reset_flag_r && wr_rst && !wbit7 && !wdt_ovf |=> !watchdog_reset_flag_r)
        else $error("written zero did not clear watchdog reset flag");

    // Written one leaves the reset flag unchanged
    AST_WATCHDOG_RESET_FLAG_ONE: assert property (@(posedge clock) disable iff (clr)
        wr_rst && wbit7 |=> watchdog_reset_flag_r == $past(watchdog_reset_flag_r))
        else $error("written one changed watchdog reset flag");

    // Counter held at zero while disabled
    AST_DISABLED_ZERO: assert property (@(posedge clock) disable iff (clr)
        !timer_enable_bit_r |=> count_register_r == `WIT_COUNT_RESET)
        else $error("counter moved while disabled");

    // Interval overflow with the event enabled raises the interrupt next cycle
    AST_INTERVAL_IRQ: assert property (@(posedge clock) disable iff (clr)
        itv_ovf && evt_en_r[`WIT_EVT_INTERVAL] && !wr_en |=> irq && !wdt_reset)
        else $error("interval overflow did not raise interrupt");

    // Reset pin is driven only during a pulse with output enabled
    AST_PIN_DRIVE: assert property (@(posedge clock) disable iff (clr)
        reset_pin_oe |-> wdt_reset && reset_output_enable_r && !reset_pin_out)
        else $error("reset pin driven outside an enabled pulse");

endmodule : wit_top

// ==== tb.sv ====
`timescale 1ns/1ps
`include "wit_map.svh"

module tb;
    // Clock, reset and reset pin
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ext_pin_n = 1'b1;
    // APB master drive
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    // Design outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wdt_reset;
    logic reset_pin_out;
    logic reset_pin_oe;
    // Bookkeeping
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h5963;
    logic [31:0] rd;
    logic err;
    // Byte addresses, four times the register index
    localparam logic [11:0] A_CTRL = {2'b00, `WIT_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_CNT = {2'b00, `WIT_IDX_COUNT, 2'b00};
    localparam logic [11:0] A_RST = {2'b00, `WIT_IDX_RSTCTRL, 2'b00};
    localparam logic [11:0] A_EVST = {2'b00, `WIT_IDX_EVT_STAT, 2'b00};
    localparam logic [11:0] A_EVEN = {2'b00, `WIT_IDX_EVT_EN, 2'b00};
    localparam logic [11:0] A_EVCL = {2'b00, `WIT_IDX_EVT_CLR, 2'b00};
    // Longest legal run is about 15k cycles; leave headroom
    localparam int LIMIT = 60000;

    wit_top DUT (
        .clock(clock),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .external_reset_pin_n(ext_pin_n),
        .irq(irq),
        .wdt_reset(wdt_reset),
        .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe)
    );

    // 40 MHz clock
    initial
    begin
        forever #12.5 clock = ~clock;
    end

    // Hang guard: a runaway wait counts as a mismatch
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fail_count++;
            test_done();
        end
    end

    // Single verdict point
    task test_done();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // Compare seen against expected, four-state exact
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read a register and compare
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        check(rd, exp);
    endtask : rd_chk

    // Expected control word; bits 4:3 read as one
    function automatic logic [31:0] ctrl_exp(logic f, logic m, logic e, logic [2:0] c);
        return {24'h000000, f, m, e, 2'b11, c};
    endfunction : ctrl_exp

    // Expected reset-control word; bits 5:0 read as one
    function automatic logic [31:0] rst_exp(logic f, logic oe);
        return {24'h000000, f, oe, 6'h3F};
    endfunction : rst_exp

    // Prescaler divisor per clock select code
    function automatic int div(logic [2:0] c);
        case (c)
            3'h0: return 2;
            3'h1: return 32;
            3'h2: return 64;
            3'h3: return 128;
            3'h4: return 256;
            3'h5: return 512;
            3'h6: return 2048;
            default: return 4096;
        endcase
    endfunction : div

    // Arm a watchdog overflow, then measure the reset pulse
    task wd_pulse(input logic oe);
        int k;
        int hi;
        apb(1'b1, A_CTRL, 8'h60);
        apb(1'b1, A_CNT, 8'hF0);
        k = 0;
        hi = 0;
        while (wdt_reset !== 1'b1 && k < 400)
        begin
            @(posedge clock);
            k++;
        end
        while (wdt_reset === 1'b1 && hi < 20)
        begin
            check(reset_pin_oe, oe);
            check(reset_pin_out, 1'b0);
            hi++;
            @(posedge clock);
        end
        check(hi, 8);
    endtask : wd_pulse

    // Main sequence
    initial
    begin
        logic [7:0] d;
        int k;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        // Reset values
        rd_chk(A_CTRL, ctrl_exp(0, 0, 0, 3'h0));
        check(err, 1'b0);
        rd_chk(A_CNT, 32'h00000000);
        rd_chk(A_RST, rst_exp(0, 0));
        rd_chk(A_EVST, 32'h00000000);
        // Unmapped address is refused
        apb(1'b1, 12'h100, 8'h5A);
        check(err, 1'b1);
        rd_chk(12'h100, 32'h00000000);
        // Random control and reset-control writes, timer kept off
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($random(seed));
            d[5] = 1'b0;
            apb(1'b1, A_CTRL, d);
            rd_chk(A_CTRL, ctrl_exp(0, d[6], 0, d[2:0]));
            apb(1'b1, A_RST, d);
            rd_chk(A_RST, rst_exp(0, d[6]));
        end
        apb(1'b1, A_RST, 8'h00);
        // Every divisor: first step after one period, so two periods give two steps
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, A_CTRL, {5'b00100, 3'(c)});
            repeat (2 * div(3'(c))) @(posedge clock);
            apb(1'b0, A_CNT, 8'h00);
            check(rd, 32'h00000002);
            apb(1'b1, A_CTRL, 8'h00);
            rd_chk(A_CNT, 32'h00000000);
        end
        // Interval overflow, then stop the timer
        apb(1'b1, A_CTRL, 8'h20);
        apb(1'b1, A_CNT, 8'hFC);
        rd = 32'h0;
        for (k = 0; k < 50 && rd[7] !== 1'b1; k++)
            apb(1'b0, A_CTRL, 8'h00);
        check(rd[7], 1'b1);
        apb(1'b1, A_CTRL, 8'h80);
        // Interrupt masked, enabled, cleared
        check(irq, 1'b0);
        apb(1'b1, A_EVST, 8'h00);
        rd_chk(A_EVST, 32'h00000001);
        apb(1'b1, A_EVEN, 8'h01);
        repeat (2) @(posedge clock);
        check(irq, 1'b1);
        apb(1'b1, A_EVCL, 8'h01);
        repeat (2) @(posedge clock);
        check(irq, 1'b0);
        // Overflow flag: only read-one then write-zero clears it
        rd_chk(A_CTRL, ctrl_exp(1, 0, 0, 3'h0));
        apb(1'b1, A_CTRL, 8'h80);
        apb(1'b1, A_CTRL, 8'h00);
        rd_chk(A_CTRL, ctrl_exp(1, 0, 0, 3'h0));
        apb(1'b1, A_CTRL, 8'h00);
        rd_chk(A_CTRL, ctrl_exp(0, 0, 0, 3'h0));
        // Watchdog overflow with pin output enabled
        apb(1'b1, A_RST, 8'h40);
        apb(1'b1, A_EVEN, 8'h02);
        wd_pulse(1'b1);
        rd_chk(A_RST, rst_exp(1, 1));
        rd_chk(A_CTRL, ctrl_exp(1, 0, 0, 3'h0));
        check(irq, 1'b1);
        rd_chk(A_EVST, 32'h00000002);
        // Written one leaves the reset flag; written zero clears it
        apb(1'b1, A_RST, 8'hC0);
        rd_chk(A_RST, rst_exp(1, 1));
        apb(1'b1, A_RST, 8'h00);
        rd_chk(A_RST, rst_exp(0, 0));
        // Pin output disabled, then the reset pin clears the flag
        wd_pulse(1'b0);
        rd_chk(A_RST, rst_exp(1, 0));
        @(posedge clock);
        ext_pin_n <= 1'b0;
        repeat (4) @(posedge clock);
        ext_pin_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd_chk(A_RST, rst_exp(0, 0));
        rd_chk(A_CTRL, ctrl_exp(0, 0, 0, 3'h0));
        check(irq, 1'b0);
        // Interval overflow with its event already enabled raises the interrupt
        apb(1'b1, A_EVEN, 8'h01);
        apb(1'b1, A_CTRL, 8'h20);
        apb(1'b1, A_CNT, 8'hFE);
        repeat (12) @(posedge clock);
        check(irq, 1'b1);
        check(wdt_reset, 1'b0);
        rd_chk(A_EVST, 32'h00000001);
        test_done();
    end
endmodule : tb
